/* File: pwmsq_top.sv */
`timescale 1ns/100ps
// Functional notes
// - pwm period programmable, up to 1 MHz
// - duty spans always low to always high
// - pwm duty counted in 1 us steps, square duty in clocks
// - any pin can carry output, sixteen at once
// - square wave 0 Hz to 4 MHz, high for half the period rounded down at zero duty
// - square pins share frequency, duty per pin
`include "pwmsq_consts.svh"
module pwmsq_top
  import pwmsq_pkg::*;
#(
  parameter int NPIN = 16,
  parameter int CW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe
);

  // cycle counts derived from the clock period
  localparam int TICK_CYC = `PWMSQ_STEP_NS / `PWMSQ_CLK_NS;
  localparam int SQ_MIN_CYC =
    (`PWMSQ_SQ_MIN_NS + `PWMSQ_CLK_NS - 1) / `PWMSQ_CLK_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  localparam logic [CW-1:0] SQ_MIN = CW'(SQ_MIN_CYC);

  // true when the offset falls in a per-channel block
  function automatic logic in_block(input logic [11:0] a,
                                    input logic [11:0] base);
    in_block = (a[11:6] == base[11:6]) && (int'(a[5:2]) < NPIN);
  endfunction

  // bus and configuration state
  logic wr_pend_reg, wr_pend_next; // write data phase pending
  logic [11:0] wr_addr_reg, wr_addr_next; // offset of pending write
  logic [31:0] hrdata_reg, hrdata_next; // registered read data
  logic [NPIN-1:0] en_reg, en_next; // pin alternate-function enables
  pwmsq_mode_t mode_reg, mode_next; // pwm or square for all pins
  logic [CW-1:0] sqp_reg, sqp_next; // square period in clocks
  logic [CW-1:0] per_reg [NPIN]; // pwm period per pin in us
  logic [CW-1:0] per_next [NPIN];
  logic [CW-1:0] duty_reg [NPIN]; // duty per pin
  logic [CW-1:0] duty_next [NPIN];
  logic [NPIN-1:0] pin_oe_next;
  logic acc; // address phase accepted this cycle
  logic [3:0] wr_idx; // channel index of pending write
  logic [3:0] rd_idx; // channel index of new read

  // timebase state
  logic [7:0] pre_reg, pre_next; // prescaler to the 1 us step
  logic tick_reg, tick_next; // one-cycle step pulse
  logic [CW-1:0] sq_cnt_reg, sq_cnt_next; // shared square counter
  logic [CW-1:0] sq_act_reg, sq_act_next; // square period in force
  logic sq_wrap; // last clock of the square period
  logic sq_run; // square period nonzero

  assign acc = hsel && hready && htrans[1];
  assign wr_idx = wr_addr_reg[5:2];
  assign rd_idx = haddr[5:2];
  logic [NPIN-1:0] pin_oe_reg; // routed-pin drive enables
  logic hreadyout_reg; // ready from the first clock after reset, zero wait states
  assign hrdata = hrdata_reg;
  assign pin_oe = pin_oe_reg;

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0 & hreadyout_reg;

  // register writes in the data phase, read data in the address phase
  always_comb begin
    wr_pend_next = acc && hwrite;
    wr_addr_next = haddr[11:0];
    en_next = en_reg;
    mode_next = mode_reg;
    sqp_next = sqp_reg;
    per_next = per_reg;
    duty_next = duty_reg;
    hrdata_next = hrdata_reg;
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        `PWMSQ_CTRL_ADDR: begin
          en_next = hwdata[NPIN-1:0];
          mode_next = hwdata[`PWMSQ_CTRL_MODE_BIT] ? PWMSQ_MODE_SQ
                                                   : PWMSQ_MODE_PWM;
        end
        `PWMSQ_SQP_ADDR: begin
          // lift short periods to the 4 MHz ceiling
          if (hwdata[CW-1:0] != '0 && hwdata[CW-1:0] < SQ_MIN) begin
            sqp_next = SQ_MIN;
          end else begin
            sqp_next = hwdata[CW-1:0];
          end
        end
        default: begin
          if (in_block(wr_addr_reg, `PWMSQ_PER_BASE)) begin
            per_next[wr_idx] = hwdata[CW-1:0];
          end else if (in_block(wr_addr_reg, `PWMSQ_DUTY_BASE)) begin
            duty_next[wr_idx] = hwdata[CW-1:0];
          end
        end
      endcase
    end
    // reads see a write finishing in the same cycle
    if (acc && !hwrite) begin
      hrdata_next = 32'h0;
      case (haddr[11:0])
        `PWMSQ_CTRL_ADDR: begin
          hrdata_next[NPIN-1:0] = en_next;
          hrdata_next[`PWMSQ_CTRL_MODE_BIT] = (mode_next == PWMSQ_MODE_SQ);
        end
        `PWMSQ_SQP_ADDR: begin
          hrdata_next[CW-1:0] = sqp_next;
        end
        `PWMSQ_STAT_ADDR: begin
          hrdata_next[NPIN-1:0] = pin_out;
          hrdata_next[`PWMSQ_CTRL_MODE_BIT] = sq_run;
        end
        default: begin
          if (in_block(haddr[11:0], `PWMSQ_PER_BASE)) begin
            hrdata_next[CW-1:0] = per_next[rd_idx];
          end else if (in_block(haddr[11:0], `PWMSQ_DUTY_BASE)) begin
            hrdata_next[CW-1:0] = duty_next[rd_idx];
          end
        end
      endcase
    end
    pin_oe_next = en_reg; // drive only routed pins
  end

  // bus and configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata_reg <= 32'h0;
      en_reg <= NPIN'(`PWMSQ_EN_RST);
      mode_reg <= PWMSQ_MODE_PWM;
      sqp_reg <= `PWMSQ_SQP_RST;
      for (int i = 0; i < NPIN; i++) begin
        per_reg[i] <= `PWMSQ_PER_RST;
        duty_reg[i] <= `PWMSQ_DUTY_RST;
      end
      pin_oe_reg <= '0;
      hreadyout_reg <= 1'b0;
    end else if (ce) begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      en_reg <= en_next;
      mode_reg <= mode_next;
      sqp_reg <= sqp_next;
      per_reg <= per_next;
      duty_reg <= duty_next;
      pin_oe_reg <= pin_oe_next;
      hreadyout_reg <= 1'b1;
    end
  end

  assign sq_wrap = (sq_act_reg == '0) || (sq_cnt_reg == sq_act_reg - 1'b1);
  assign sq_run = sq_act_reg != '0;

  // 1 us step and shared square counter
  always_comb begin
    tick_next = (pre_reg == TICK_LAST);
    pre_next = tick_next ? 8'h00 : pre_reg + 8'h01;
    if (sq_wrap) begin
      // square period changes only at its end
      sq_cnt_next = '0;
      sq_act_next = sqp_reg; // zero holds pins low: 0 Hz
    end else begin
      sq_cnt_next = sq_cnt_reg + 1'b1;
      sq_act_next = sq_act_reg;
    end
  end

  // timebase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= 8'h00;
      tick_reg <= 1'b0;
      sq_cnt_reg <= '0;
      sq_act_reg <= '0;
    end else if (ce) begin
      pre_reg <= pre_next;
      tick_reg <= tick_next;
      sq_cnt_reg <= sq_cnt_next;
      sq_act_reg <= sq_act_next;
    end
  end

  // one channel per pin, all sharing step and square timing
  for (genvar g = 0; g < NPIN; g++) begin : g_ch
    pwmsq_channel #(
      .CW(CW)
    ) u_ch (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .enable(en_reg[g]),
      .sq_mode(mode_reg == PWMSQ_MODE_SQ),
      .tick(tick_reg),
      .sq_run(sq_run),
      .sq_wrap(sq_wrap),
      .sq_cnt(sq_cnt_reg),
      .sq_half(sq_act_reg >> 1), // half the period, rounded down
      .period_in(per_reg[g]),
      .duty_in(duty_reg[g]),
      .pwm_out(pin_out[g])
    );
  end

  tick_spacing_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tick_reg && $past(ce)) |-> $past(pre_reg) == TICK_LAST)
    else $error("step pulse not one microsecond apart");

  sq_min_period_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sq_run |-> sq_act_reg >= SQ_MIN)
    else $error("square period above 4 MHz");

  sq_reload_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !sq_wrap) |=> $stable(sq_act_reg))
    else $error("square period changed mid-period");

  pin_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pin_out & ~pin_oe) == '0)
    else $error("output high on an unrouted pin");

  // bus-side checks
  // a control write lands in the pin enables
  ctrl_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && wr_pend_reg && wr_addr_reg == `PWMSQ_CTRL_ADDR)
    |=> en_reg == $past(hwdata[NPIN-1:0]))
    else $error("control write did not reach the enables");

  // the mode bit of a control write picks square or pwm
  mode_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && wr_pend_reg && wr_addr_reg == `PWMSQ_CTRL_ADDR)
    |=> (mode_reg == PWMSQ_MODE_SQ) == $past(hwdata[`PWMSQ_CTRL_MODE_BIT]))
    else $error("control write did not set the mode");

  // a square period at or above the floor is kept as written
  sqp_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && wr_pend_reg && wr_addr_reg == `PWMSQ_SQP_ADDR
     && hwdata[CW-1:0] >= SQ_MIN) |=> sqp_reg == $past(hwdata[CW-1:0]))
    else $error("square period write lost");

  // stored square period is off or no faster than 4 MHz
  sqp_floor_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sqp_reg == '0 || sqp_reg >= SQ_MIN)
    else $error("stored square period below the floor");

  // a period write lands in the addressed channel
  per_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && wr_pend_reg && in_block(wr_addr_reg, `PWMSQ_PER_BASE))
    |=> per_reg[$past(wr_idx)] == $past(hwdata[CW-1:0]))
    else $error("period write missed its channel");

  // read data stands until the next accepted read
  read_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(acc && !hwrite) |=> $stable(hrdata_reg))
    else $error("read data changed without a read");

  // once up after reset the bus never inserts a wait state
  ready_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout |=> hreadyout)
    else $error("wait state inserted");

  // drive enables follow the pin enables one clock later
  oe_follow_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce |=> pin_oe == $past(en_reg))
    else $error("drive enable did not follow the pin enable");

  // timebase and pin checks
  // the step pulse lasts one clock
  tick_pulse_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick_reg) |=> !tick_reg)
    else $error("step pulse longer than one clock");

  // prescaler never passes its last count
  pre_bound_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pre_reg <= TICK_LAST)
    else $error("prescaler ran past its last count");

  // shared square counter stays inside the period in force
  sq_count_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sq_run |-> sq_cnt_reg < sq_act_reg)
    else $error("square counter left its period");

  // square mode at zero hertz holds every pin low
  sq_off_low_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && mode_reg == PWMSQ_MODE_SQ && !sq_run) |=> pin_out == '0)
    else $error("pin high while the square output is off");

endmodule // pwmsq_top

/* File: pwmsq_consts.svh */
`ifndef PWMSQ_CONSTS_SVH
`define PWMSQ_CONSTS_SVH

// register byte offsets inside the 4 kbyte slave window
`define PWMSQ_CTRL_ADDR 12'h000
`define PWMSQ_SQP_ADDR 12'h004
`define PWMSQ_STAT_ADDR 12'h008
`define PWMSQ_PER_BASE 12'h040
`define PWMSQ_DUTY_BASE 12'h080

// field positions
`define PWMSQ_CTRL_MODE_BIT 16

// reset values
`define PWMSQ_EN_RST 16'h0000
`define PWMSQ_SQP_RST 16'h0000
`define PWMSQ_PER_RST 16'h03e8
`define PWMSQ_DUTY_RST 16'h0000

// timing figures in ns
`define PWMSQ_CLK_NS 50
`define PWMSQ_STEP_NS 1000
`define PWMSQ_SQ_MIN_NS 250

`endif

/* File: pwmsq_pkg.sv */
package pwmsq_pkg;
  // output mode shared by all pins, one-hot
  typedef enum logic [1:0] {
    PWMSQ_MODE_PWM = 2'b01,
    PWMSQ_MODE_SQ = 2'b10
  } pwmsq_mode_t;
endpackage

/* File: pwmsq_channel.sv */
`timescale 1ns/100ps
`include "pwmsq_consts.svh"
// one output channel: pulse-width counter plus square-wave compare
module pwmsq_channel
  import pwmsq_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic sq_mode,
  input wire logic tick,
  input wire logic sq_run,
  input wire logic sq_wrap,
  input wire logic [CW-1:0] sq_cnt,
  input wire logic [CW-1:0] sq_half,
  input wire logic [CW-1:0] period_in,
  input wire logic [CW-1:0] duty_in,
  output logic pwm_out
);

  logic [CW-1:0] cnt_reg, cnt_next; // step counter within period
  logic [CW-1:0] per_reg, per_next; // period in force
  logic [CW-1:0] duty_reg, duty_next; // high time in force
  logic out_next;
  logic [CW:0] cnt_inc; // widened to avoid wrap on compare
  logic [CW-1:0] per_eff; // period with zero lifted to one step
  logic [CW-1:0] sq_high; // square high time in clocks
  logic wrap; // last step of the current period

  assign cnt_inc = {1'b0, cnt_reg} + {{CW{1'b0}}, 1'b1};
  assign per_eff = (period_in == '0) ? {{(CW-1){1'b0}}, 1'b1} : period_in;
  assign wrap = tick && (cnt_inc >= {1'b0, per_reg});
  // zero duty in square mode means high for half the period, rounded down
  assign sq_high = (duty_reg == '0) ? sq_half : duty_reg;

  // next counter, settings and pin level
  always_comb begin
    cnt_next = cnt_reg;
    per_next = per_reg;
    duty_next = duty_reg;
    if (!enable) begin
      // idle: take settings at once, restart clean
      cnt_next = '0;
      per_next = per_eff;
      duty_next = duty_in;
    end else if (sq_mode) begin
      // square: new duty only at shared period end
      cnt_next = '0;
      per_next = per_eff;
      if (sq_wrap) begin
        duty_next = duty_in;
      end
    end else if (wrap) begin
      // end of period: reload
      cnt_next = '0;
      per_next = per_eff; // at least one 1 us step
      duty_next = duty_in;
    end else if (tick) begin
      cnt_next = cnt_inc[CW-1:0]; // one step per us
    end
    if (!enable) begin
      out_next = 1'b0;
    end else if (sq_mode) begin
      out_next = sq_run && (sq_cnt < sq_high);
    end else begin
      // duty 0 never high, duty >= period always high
      out_next = cnt_next < duty_next;
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      per_reg <= `PWMSQ_PER_RST;
      duty_reg <= `PWMSQ_DUTY_RST;
      pwm_out <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      per_reg <= per_next;
      duty_reg <= duty_next;
      pwm_out <= out_next;
    end
  end

  zero_duty_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !sq_mode && duty_reg == '0 && duty_in == '0) |=> !pwm_out)
    else $error("zero duty produced a high level");

  full_duty_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && enable && !sq_mode && duty_reg >= per_reg && period_in != '0
     && duty_in >= period_in) |=> pwm_out)
    else $error("full duty produced a low level");

  count_bound_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    per_reg != '0 && cnt_reg < per_reg)
    else $error("step counter left its period");

  step_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !tick && enable && !sq_mode && $past(enable)
     && !$past(sq_mode)) |=> $stable(pwm_out))
    else $error("level changed between 1 us steps");

  reload_edge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && enable && !sq_mode && !wrap)
    |=> (per_reg == $past(per_reg) && duty_reg == $past(duty_reg)))
    else $error("settings changed inside a period");

  sq_phase_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && enable && sq_mode && sq_run && sq_cnt == '0 && sq_high != '0)
    |=> pwm_out)
    else $error("square pin missed the common rising edge");

endmodule // pwmsq_channel

/* File: pwmsq_load.sv */
`timescale 1ns/100ps
// external loads on the sixteen pins, each with a pull-down
module pwmsq_load (
  input wire logic hclk,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  output int high_len [16],
  output int period_len [16]
);
  logic [15:0] prev_lvl = 16'h0000; // level seen one cycle ago
  int cyc [16]; // cycles since the last rising edge
  int hi [16]; // high cycles since the last rising edge
  // a pin that is not driven is pulled low
  wire logic [15:0] lvl = pin_out & pin_oe;
  // measure high time and period between rising edges
  always @(posedge hclk) begin
    for (int i = 0; i < 16; i++) begin
      if (lvl[i] && !prev_lvl[i]) begin // rising edge closes a period
        period_len[i] <= cyc[i];
        high_len[i] <= hi[i];
        cyc[i] <= 1;
        hi[i] <= 1;
      end else begin
        cyc[i] <= cyc[i] + 1;
        hi[i] <= hi[i] + int'(lvl[i]);
      end
    end
    prev_lvl <= lvl;
  end
endmodule // pwmsq_load

/* File: pwm_and_square_wave_outputs_bench.sv */
`timescale 1ns/100ps
`include "pwmsq_consts.svh"
// register-level tests of the pulse-width and square-wave outputs
module pwm_and_square_wave_outputs_bench;
  logic hclk = 1'b0; // 20 mhz bus clock
  logic hresetn = 1'b0; // active-low reset
  logic ce = 1'b1; // clock enable, low freezes all state
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [31:0] last_rd; // read data taken at the closing edge
  int high_len [16];
  int period_len [16];
  int failures = 0;
  int comparisons = 0;
  // half period 25 ns
  always #25 hclk = ~hclk;
  pwmsq_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_out(pin_out),
    .pin_oe(pin_oe));
  pwmsq_load LOAD (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .high_len(high_len), .period_len(period_len));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // wait for hready seen high at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t bus ready timeout", $time);
    end
    last_rd = hrdata;
    @(posedge hclk);
  endtask
  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic [11:0] a, input logic w,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(last_rd, e);
  endtask
  // measured high time and period of one pin, in clocks
  task automatic wave(input int i, input int h, input int p);
    @(negedge hclk);
    chk(high_len[i], h);
    chk(period_len[i], p);
    @(posedge hclk);
  endtask
  // pin must hold one level for n clocks
  task automatic flat(input int i, input logic e, input int n);
    logic [31:0] bad;
    bad = 0;
    repeat (n) begin
      @(negedge hclk);
      if (pin_out[i] !== e) bad++;
    end
    chk(bad, 32'h0);
    @(posedge hclk);
  endtask
  // wait until a pin rises, bounded
  task automatic rise(input int i);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (pin_out[i] !== 1'b0 && n < 2000);
    do begin
      @(negedge hclk);
      n++;
    end while (pin_out[i] !== 1'b1 && n < 2000);
    if (pin_out[i] !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t pin %0d never rose", $time, i);
    end
    @(posedge hclk);
  endtask
  task automatic final_report();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge hclk);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    // reset values and unmapped place
    rdc(`PWMSQ_CTRL_ADDR, 32'h0);
    rdc(`PWMSQ_SQP_ADDR, 32'h0);
    rdc(`PWMSQ_PER_BASE + 12'h03c, 32'h3e8);
    rdc(`PWMSQ_DUTY_BASE, 32'h0);
    wr(12'h100, 32'h1234);
    rdc(12'h100, 32'h0);
    // every pin its own period, half duty, all sixteen at once
    for (int i = 0; i < 16; i++) begin
      wr(`PWMSQ_PER_BASE + 12'(4 * i), 32'(i + 2));
      wr(`PWMSQ_DUTY_BASE + 12'(4 * i), 32'((i + 2) / 2));
    end
    rdc(`PWMSQ_PER_BASE + 12'h020, 32'ha);
    wr(`PWMSQ_CTRL_ADDR, 32'hffff);
    repeat (1100) @(posedge hclk);
    chk(pin_oe, 32'hffff);
    for (int i = 0; i < 16; i++) begin
      wave(i, 20 * ((i + 2) / 2), 20 * (i + 2));
    end
    // new setting mid-period: running period completes unchanged
    rise(2);
    repeat (10) @(posedge hclk);
    wr(`PWMSQ_PER_BASE + 12'h008, 32'h8);
    wr(`PWMSQ_DUTY_BASE + 12'h008, 32'h6);
    rise(2);
    wave(2, 40, 80);
    rise(2);
    wave(2, 120, 160);
    // always low, duty equal to period and above it
    wr(`PWMSQ_DUTY_BASE + 12'h00c, 32'h0);
    wr(`PWMSQ_DUTY_BASE + 12'h010, 32'h6);
    wr(`PWMSQ_DUTY_BASE + 12'h014, 32'h64);
    repeat (400) @(posedge hclk);
    flat(3, 1'b0, 200);
    flat(4, 1'b1, 200);
    flat(5, 1'b1, 200);
    // square mode, shortest period, two pins with own duty
    wr(`PWMSQ_DUTY_BASE, 32'h0);
    wr(`PWMSQ_DUTY_BASE + 12'h004, 32'h3);
    wr(`PWMSQ_SQP_ADDR, 32'h2);
    rdc(`PWMSQ_SQP_ADDR, 32'h5);
    wr(`PWMSQ_CTRL_ADDR, 32'h0001_0003);
    repeat (100) @(posedge hclk);
    chk(pin_oe, 32'h3);
    ahb(`PWMSQ_STAT_ADDR, 1'b0, 32'h0);
    chk(last_rd & 32'h0001_0000, 32'h0001_0000);
    wave(0, 2, 5);
    wave(1, 3, 5);
    wr(`PWMSQ_SQP_ADDR, 32'h8);
    repeat (100) @(posedge hclk);
    wave(0, 4, 8);
    wave(1, 3, 8);
    // clock enable low: a square pin just risen must stay high
    rise(0);
    ce <= 1'b0;
    flat(0, 1'b1, 60);
    ce <= 1'b1;
    // zero hertz: the output stops
    wr(`PWMSQ_SQP_ADDR, 32'h0);
    repeat (50) @(posedge hclk);
    flat(0, 1'b0, 100);
    chk(hresp, 32'h0);
    final_report();
  end
endmodule // pwm_and_square_wave_outputs_bench
